// ==== inc/ssu_pkg.sv ====
// Purpose: Shared constants and types for the serial shift unit
// Assumes: System clock 40 MHz; pins sampled through two flops
// Notes: Control bits are plain ports, no register bus
// Notes on behaviour
// - Output pin fed by transparent latch of MSB
// - Serial input always from serial input pin
// - Four-bit counter CPU readable, writable, overflow request
// - Shift register and counter share one tick, except with the pin clock
// - External clock counts both pin edges
// - Clock from pin, timer match or strobe
// - Two-wire: start interrupt, clock held for waits
// - Three-wire behaves as SPI modes 0/1
// - Eight clocks exchange bytes; overflow marks done
// - Toggle strobe toggles shift clock pin
// - Edge select picks sampling and shifting edges
// - Load data and clear counter before transfer
// - Sixteen external edges overflow, wake from idle
// - Two-wire follows I2C, no filtering or slew
// - Only master clocks, only slave stretches
// - Data falling while clock high sets start
// - Start holds clock low until flag cleared
// - Two-wire slave samples data on clock rise
// - Overflow forces clock low until released
// - Preset fourteen gives overflow after acknowledge
// - Data line low if MSB or port zero
// - Start flag cleared only by writing one
// - Overflow flag set on wrap 15 to 0
// - CPU write beats simultaneous shift
// - Stop detection sets non-interrupt stop flag
package ssu_pkg;
    // Widths and positions
    localparam int SSU_DATA_W = 8;
    localparam int SSU_CNT_W = 4;
    localparam int SSU_MSB = 7;
    localparam int SSU_FIFO_DEPTH = 4;
    // Reset values
    localparam logic [7:0] SSU_DATA_RST = 8'h00;
    localparam logic [3:0] SSU_CNT_RST = 4'h0;
    localparam logic [3:0] SSU_CNT_MAX = 4'hF;
    // Wire modes
    typedef enum logic [1:0] {
        SSU_WM_OFF = 2'h0,
        SSU_WM_THREE = 2'h1,
        SSU_WM_TWO = 2'h2,
        SSU_WM_TWO_HOLD = 2'h3
    } ssu_wire_mode_t;
    // Control bundle from the CPU side
    typedef struct packed {
        ssu_wire_mode_t wire_mode;
        logic external_clock_select;
        logic clock_edge_select;
        logic software_clock_strobe;
        logic clock_toggle_strobe;
    } ssu_ctrl_t;
    // Flag bundle shown to the CPU
    typedef struct packed {
        logic start_condition_flag;
        logic counter_overflow_flag;
        logic stop_condition_flag;
        logic collision;
    } ssu_flags_t;
endpackage : ssu_pkg

// ==== logic/ssu_core.sv ====
// Purpose: Serial shift unit with counter, output latch and two-wire clock control
// Assumes: Pins arrive asynchronously and are synchronised on clk_sys
// Notes: Received bytes also pushed into a small FIFO for the CPU
`timescale 1ns/1ps
`default_nettype none

// Small flop FIFO with valid/ready on both sides
module ssu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage flops
    logic [AW-1:0] wr_ptr;          // Write index
    logic [AW-1:0] rd_ptr;          // Read index
    logic [AW:0] level;             // Words held
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Accept only while below depth; a full FIFO refuses the word
    assign in_ready = (level < (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];
    // Storage writes
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // Pointers and fill level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ssu_fifo

module ssu_core
    import ssu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // CPU control
    input wire ssu_ctrl_t ctrl,
    input wire logic timer_match,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic cnt_wr,
    input wire logic [3:0] cnt_wdata,
    input wire logic clr_start,
    input wire logic clr_overflow,
    input wire logic clr_stop,
    input wire logic port_data_out,
    input wire logic port_clock_out,
    // CPU status
    output logic [7:0] shift_register,
    output logic [3:0] count,
    output ssu_flags_t flags,
    output logic irq_start,
    output logic irq_overflow,
    output logic wake_idle,
    // Received byte stream
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_overrun,
    // Pins
    input wire logic serial_in_pin,
    input wire logic shift_clock_pin_in,
    output logic data_out_pin,
    output logic sda_out,
    output logic sda_oe,
    output logic shift_clock_pin_out,
    output logic scl_out,
    output logic scl_oe
);
    // Synchroniser stages
    logic [1:0] di_sync;
    logic [1:0] ck_sync;
    logic di_s;             // Synchronised data line
    logic ck_s;             // Synchronised clock line
    logic di_d;             // Delayed copy for edges
    logic ck_d;
    logic ck_rise;
    logic ck_fall;
    logic di_fall;
    logic di_rise;
    logic two_wire;
    logic shift_tick;       // Selected shift clock
    logic cnt_tick;         // Selected counter clock
    logic out_latch;        // Output latch of MSB
    logic latch_open;
    logic start_hold;       // Stretch after start
    logic ovf_hold;         // Stretch after overflow
    logic clk_toggle;       // Software driven clock level
    logic [3:0] next_count;
    logic wrap;
    logic byte_done;        // Byte complete, pushed one cycle after wrap
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    assign two_wire = ctrl.wire_mode[1];
    assign di_s = di_sync[1];
    assign ck_s = ck_sync[1];
    assign ck_rise = ck_s && !ck_d;
    assign ck_fall = !ck_s && ck_d;
    assign di_fall = !di_s && di_d;
    assign di_rise = di_s && !di_d;

    // Two-flop synchronisers on the pins
    // Reset high so an idle two-wire line shows no edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            di_sync <= 2'h3;
            ck_sync <= 2'h3;
            di_d <= 1'b1;
            ck_d <= 1'b1;
        end else begin
            di_sync <= {di_sync[0], serial_in_pin};
            ck_sync <= {ck_sync[0], shift_clock_pin_in};
            di_d <= di_s;
            ck_d <= ck_s;
        end
    end

    // Clock source selection
    // Pin edges, timer event or software strobe drive the shift tick and the counter tick; with the pin clock they differ
    always_comb begin
        shift_tick = 1'b0;
        cnt_tick = 1'b0;
        if (ctrl.external_clock_select) begin
            // Edge select 0 samples on rise, 1 on fall
            shift_tick = ctrl.clock_edge_select ? ck_fall : ck_rise;
            cnt_tick = ck_rise || ck_fall || (ctrl.software_clock_strobe && ctrl.clock_toggle_strobe);
        end else if (ctrl.clock_edge_select) begin
            shift_tick = timer_match;
            cnt_tick = timer_match;
        end else begin
            shift_tick = ctrl.software_clock_strobe;
            cnt_tick = ctrl.software_clock_strobe;
        end
    end

    // Shift register, CPU write wins over shift
    // Left shift, new bit enters at bit 0
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_register <= SSU_DATA_RST;
        end else if (data_wr) begin
            shift_register <= data_wdata;
        end else if (shift_tick) begin
            shift_register <= {shift_register[SSU_MSB-1:0], di_s};
        end
    end

    // Counter, CPU access wins
    // Wrap seen only on a real tick at the top count
    assign wrap = cnt_tick && (count == SSU_CNT_MAX);
    always_comb begin
        next_count = count;
        if (cnt_wr) begin
            next_count = cnt_wdata;
        end else if (cnt_tick) begin
            next_count = count + 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= SSU_CNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // Output latch: open in first half with external clock
    // Closed in the sampling half so the output moves on the other edge
    assign latch_open = !ctrl.external_clock_select || (ck_s == ctrl.clock_edge_select);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_latch <= 1'b0;
        end else if (latch_open) begin
            out_latch <= shift_register[SSU_MSB];
        end
    end

    // Flags; set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            if (two_wire && ck_s && di_fall) begin
                flags.start_condition_flag <= 1'b1;
            end else if (clr_start) begin
                flags.start_condition_flag <= 1'b0;
            end
            if (!cnt_wr && wrap) begin
                flags.counter_overflow_flag <= 1'b1;
            end else if (clr_overflow) begin
                flags.counter_overflow_flag <= 1'b0;
            end
            if (two_wire && ck_s && di_rise) begin
                flags.stop_condition_flag <= 1'b1;
            end else if (clr_stop) begin
                flags.stop_condition_flag <= 1'b0;
            end
            flags.collision <= two_wire && (shift_register[SSU_MSB] != di_s);
        end
    end

    // Interrupt requests and wake
    // Level requests follow the flags one cycle later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_start <= 1'b0;
            irq_overflow <= 1'b0;
            wake_idle <= 1'b0;
        end else begin
            irq_start <= flags.start_condition_flag;
            irq_overflow <= flags.counter_overflow_flag;
            wake_idle <= flags.counter_overflow_flag;
        end
    end

    // Clock stretching holds, slave side only
    // Start hold begins at the master's first falling clock edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_hold <= 1'b0;
            ovf_hold <= 1'b0;
        end else begin
            if (!two_wire || clr_start) begin
                start_hold <= 1'b0;
            end else if (flags.start_condition_flag && ck_fall) begin
                start_hold <= 1'b1;
            end
            if (ctrl.wire_mode != SSU_WM_TWO_HOLD) begin
                ovf_hold <= 1'b0;
            end else if (!cnt_wr && wrap) begin
                ovf_hold <= 1'b1;
            end else if (clr_overflow) begin
                // Release only when no new overflow arrives, like the flag
                ovf_hold <= 1'b0;
            end
        end
    end

    // Software toggled clock level
    // Each toggle strobe flips the clock level once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_toggle <= 1'b0;
        end else if (ctrl.clock_toggle_strobe) begin
            clk_toggle <= !clk_toggle;
        end
    end

    // Pin drivers; two-wire lines are open drain, no filtering
    // Port bit XOR toggle level high releases the clock line, low pulls it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_out_pin <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            shift_clock_pin_out <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            data_out_pin <= out_latch;
            sda_out <= 1'b0;
            sda_oe <= two_wire && !(out_latch && port_data_out);
            shift_clock_pin_out <= port_clock_out ^ clk_toggle;
            scl_out <= 1'b0;
            scl_oe <= two_wire && (start_hold || ovf_hold || !(port_clock_out ^ clk_toggle));
        end
    end

    // Byte complete: the last shift has landed one cycle after the wrap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byte_done <= 1'b0;
        end else begin
            byte_done <= !cnt_wr && wrap;
        end
    end

    // Completed bytes buffered for the CPU
    ssu_fifo #(.WIDTH(SSU_DATA_W), .DEPTH(SSU_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(byte_done),
        .in_ready(fifo_in_ready),
        .in_data(shift_register),
        .out_valid(fifo_out_valid),
        .out_ready(rx_valid && rx_ready),
        .out_data(fifo_out_data)
    );
    // Output stage mirrors the head; a taken word blanks valid for one cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_data <= SSU_DATA_RST;
            rx_overrun <= 1'b0;
        end else begin
            rx_valid <= fifo_out_valid && !(rx_valid && rx_ready);
            rx_data <= fifo_out_data;
            rx_overrun <= byte_done && !fifo_in_ready;
        end
    end

    // Checks
    a_cpu_write_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        data_wr |=> shift_register == $past(data_wdata))
        else $error("shift register lost CPU write");
    a_wrap_sets_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrap && !cnt_wr) |=> flags.counter_overflow_flag && count == 4'h0)
        else $error("overflow flag not set on wrap");
    a_start_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (two_wire && ck_s && di_fall) |=> flags.start_condition_flag)
        else $error("start not flagged");
    a_start_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flags.start_condition_flag && !clr_start) |=> flags.start_condition_flag)
        else $error("start flag cleared without write");
    a_ext_both_edges: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl.external_clock_select && ck_fall && !cnt_wr) |=> count == $past(count) + 4'h1)
        else $error("falling edge not counted");
    a_shift_takes_di: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (shift_tick && !data_wr) |=> shift_register[0] == $past(di_s))
        else $error("shift did not take input");
    a_sda_pull_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (two_wire && !port_data_out) |=> sda_oe)
        else $error("data line not pulled low");
    a_ovf_hold_scl: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf_hold |=> scl_oe)
        else $error("clock not held after overflow");
    a_sixteen_edges: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (count == 4'hF && cnt_tick && !cnt_wr) |=> ##1 irq_overflow)
        else $error("no overflow request");
    a_stop_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (two_wire && ck_s && di_rise) |=> flags.stop_condition_flag)
        else $error("stop not flagged");
    a_start_hold_scl: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_hold && two_wire) |=> scl_oe)
        else $error("clock not held after start");
    a_toggle_flips: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl.clock_toggle_strobe |=> clk_toggle != $past(clk_toggle))
        else $error("toggle strobe did not flip clock level");
    a_cnt_write_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cnt_wr |=> count == $past(cnt_wdata))
        else $error("counter lost CPU write");
    // Covers for the main scenarios
    c_start_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) flags.start_condition_flag);
    c_byte_done: cover property (@(posedge clk_sys) disable iff (!rst_n) rx_valid && rx_ready);
    c_stretch: cover property (@(posedge clk_sys) disable iff (!rst_n) start_hold ##[1:50] ovf_hold);
    c_spi_byte: cover property (@(posedge clk_sys) disable iff (!rst_n) ctrl.external_clock_select && !two_wire && wrap);
    c_overrun: cover property (@(posedge clk_sys) disable iff (!rst_n) rx_overrun);
endmodule : ssu_core

`default_nettype wire

// ==== bench/ssu_far_master.sv ====
// Purpose: Remote master on the data and clock pins
// Assumes: Link clock of 200 ns, held low between frames
// Notes: Samples returning data late in the high phase to cover pin sync delay
`timescale 1ns/1ps
`default_nettype none
module ssu_far_master (
    input wire logic miso,
    output logic mosi,
    output logic sck
);
    // Idle levels at time zero
    initial begin
        mosi = 1'b1;
        sck = 1'b0;
    end
    // Set both lines directly, one means released in two-wire use
    task automatic lines(input logic d, input logic c);
        mosi = d;
        sck = c;
    endtask : lines
    // One byte, MSB first, data set half a cycle before the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #100 sck = 1'b1;
            #75 rx[i] = miso;
            #25 sck = 1'b0;
        end
        // Released line shows the inverse of the last bit
        mosi = ~tx[0];
    endtask : xfer
    // One clock pulse, two edges
    task automatic pulse;
        #100 sck = 1'b1;
        #100 sck = 1'b0;
    endtask : pulse
endmodule : ssu_far_master
`default_nettype wire

// ==== bench/serial_shift_unit_bench.sv ====
// Purpose: Self-checking bench for the serial shift unit
// Assumes: Far master model drives data and clock pins
// Notes: Two-wire lines are open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
module serial_shift_unit_bench;
    import ssu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    ssu_ctrl_t ctrl = '0;
    logic timer_match = 1'b0, data_wr = 1'b0, cnt_wr = 1'b0, clr_start = 1'b0, clr_overflow = 1'b0;
    logic rx_ready = 1'b0, port_data_out = 1'b1, ovr_seen = 1'b0, port_clock_out = 1'b1;
    logic [7:0] data_wdata = 8'h00;
    logic [3:0] cnt_wdata = 4'h0;
    logic [7:0] shift_register, rx_data, far_rx;
    logic [3:0] count;
    ssu_flags_t flags;
    logic irq_start, irq_overflow, wake_idle, rx_valid, rx_overrun, data_out_pin;
    logic sda_oe, scl_oe, shift_clock_pin_out, mosi, sck;
    int n_mismatch = 0, comparisons = 0;
    // Clock and sticky overrun
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rx_overrun === 1'b1) ovr_seen <= 1'b1;
    ssu_core i_ssu_core (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl), .timer_match(timer_match),
        .data_wr(data_wr), .data_wdata(data_wdata), .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata),
        .clr_start(clr_start), .clr_overflow(clr_overflow), .clr_stop(1'b0), .port_data_out(port_data_out),
        .port_clock_out(port_clock_out), .shift_register(shift_register), .count(count), .flags(flags),
        .irq_start(irq_start), .irq_overflow(irq_overflow), .wake_idle(wake_idle), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun), .serial_in_pin(mosi & ~sda_oe),
        .shift_clock_pin_in(sck & ~scl_oe), .data_out_pin(data_out_pin), .sda_out(), .sda_oe(sda_oe),
        .shift_clock_pin_out(shift_clock_pin_out), .scl_out(), .scl_oe(scl_oe));
    ssu_far_master i_ssu_far_master (.miso(data_out_pin), .mosi(mosi), .sck(sck));
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : cyc
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // Write data and counter in one cycle
    task automatic load(input logic [7:0] d, input logic [3:0] c);
        data_wr = 1'b1;
        data_wdata = d;
        cnt_wr = 1'b1;
        cnt_wdata = c;
        cyc(1);
        data_wr = 1'b0;
        cnt_wr = 1'b0;
        cyc(1);
    endtask : load
    task automatic sstb;
        ctrl.software_clock_strobe = 1'b1;
        cyc(1);
        ctrl.software_clock_strobe = 1'b0;
        cyc(3);
    endtask : sstb
    task automatic clrovf;
        clr_overflow = 1'b1;
        cyc(1);
        clr_overflow = 1'b0;
        cyc(2);
    endtask : clrovf
    // Bounded wait for the overflow flag
    task automatic wovf;
        int i;
        for (i = 0; i < 4000 && flags.counter_overflow_flag !== 1'b1; i++) cyc(1);
        if (i == 4000) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : wovf
    // Software strobes, write beats shift, toggle strobe
    task automatic t_soft;
        logic p;
        i_ssu_far_master.lines(1'b1, 1'b0);
        ctrl.wire_mode = SSU_WM_THREE;
        load(8'hA5, 4'h0);
        repeat (3) sstb();
        chk("shift", shift_register, 8'h2F);
        chk("count", {4'h0, count}, 8'h03);
        chk("dout", {7'h0, data_out_pin}, 8'h00);
        data_wr = 1'b1;
        data_wdata = 8'hC3;
        ctrl.software_clock_strobe = 1'b1;
        cyc(1);
        data_wr = 1'b0;
        ctrl.software_clock_strobe = 1'b0;
        cyc(3);
        chk("shift", shift_register, 8'hC3);
        chk("dout", {7'h0, data_out_pin}, 8'h01);
        p = shift_clock_pin_out;
        ctrl.clock_toggle_strobe = 1'b1;
        cyc(1);
        ctrl.clock_toggle_strobe = 1'b0;
        cyc(3);
        chk("sck out", {7'h0, shift_clock_pin_out}, {7'h0, ~p});
        ctrl.clock_toggle_strobe = 1'b1;
        cyc(1);
        ctrl.clock_toggle_strobe = 1'b0;
        cyc(3);
        chk("sck out", {7'h0, shift_clock_pin_out}, {7'h0, p});
        $display("test soft done");
    endtask : t_soft
    // Wrap from 15, flags, timer source
    task automatic t_wrap;
        load(8'h01, 4'hF);
        sstb();
        chk("count", {4'h0, count}, 8'h00);
        chk("ovf", {7'h0, flags.counter_overflow_flag}, 8'h01);
        cyc(1);
        chk("irq ovf", {7'h0, irq_overflow}, 8'h01);
        chk("wake", {7'h0, wake_idle}, 8'h01);
        clrovf();
        chk("ovf", {7'h0, flags.counter_overflow_flag}, 8'h00);
        ctrl.clock_edge_select = 1'b1;
        timer_match = 1'b1;
        cyc(1);
        timer_match = 1'b0;
        cyc(3);
        chk("count", {4'h0, count}, 8'h01);
        ctrl.clock_edge_select = 1'b0;
        $display("test wrap done");
    endtask : t_wrap
    // Fill the byte buffer past full, then drain
    task automatic t_fifo;
        logic [7:0] q[$];
        logic [7:0] d;
        rx_ready = 1'b1;
        cyc(8);
        rx_ready = 1'b0;
        ovr_seen = 1'b0;
        d = 8'h00;
        for (int i = 1; i <= 5; i++) begin
            d = d + 8'h11;
            load(d, 4'hF);
            sstb();
            if (i < 5) q.push_back({d[6:0], 1'b1});
            clrovf();
        end
        chk("overrun", {7'h0, ovr_seen}, 8'h01);
        rx_ready = 1'b1;
        for (int n = 0; n < 20 && q.size() > 0; n++) begin
            if (rx_valid === 1'b1) chk("rx", rx_data, q.pop_front());
            cyc(1);
        end
        cyc(2);
        chk("left", 8'(q.size()), 8'h00);
        chk("rx valid", {7'h0, rx_valid}, 8'h00);
        $display("test fifo done");
    endtask : t_fifo
    // Full byte exchange on the pin clock
    task automatic t_spi;
        load(8'hC3, 4'h0);
        clrovf();
        ctrl.external_clock_select = 1'b1;
        cyc(4);
        i_ssu_far_master.xfer(8'h96, far_rx);
        wovf();
        cyc(2);
        chk("shift", shift_register, 8'h96);
        chk("far rx", far_rx, 8'hC3);
        chk("count", {4'h0, count}, 8'h00);
        clrovf();
        ctrl.external_clock_select = 1'b0;
        $display("test spi done");
    endtask : t_spi
    // Two-wire data drive, start, hold, stop, acknowledge preset
    task automatic t_tw;
        i_ssu_far_master.lines(1'b1, 1'b0);
        ctrl.wire_mode = SSU_WM_TWO;
        load(8'h7F, 4'h0);
        cyc(2);
        chk("sda oe", {7'h0, sda_oe}, 8'h01);
        load(8'h80, 4'h0);
        cyc(2);
        chk("sda oe", {7'h0, sda_oe}, 8'h00);
        port_data_out = 1'b0;
        cyc(3);
        chk("sda oe", {7'h0, sda_oe}, 8'h01);
        cyc(2);
        chk("collision", {7'h0, flags.collision}, 8'h01);
        port_data_out = 1'b1;
        load(8'hFF, 4'h0);
        cyc(2);
        i_ssu_far_master.lines(1'b1, 1'b1);
        cyc(16);
        i_ssu_far_master.lines(1'b0, 1'b1);
        cyc(16);
        chk("start", {7'h0, flags.start_condition_flag}, 8'h01);
        chk("irq start", {7'h0, irq_start}, 8'h01);
        i_ssu_far_master.lines(1'b0, 1'b0);
        cyc(8);
        chk("scl oe", {7'h0, scl_oe}, 8'h01);
        clr_start = 1'b1;
        cyc(1);
        clr_start = 1'b0;
        cyc(4);
        chk("scl oe", {7'h0, scl_oe}, 8'h00);
        chk("start", {7'h0, flags.start_condition_flag}, 8'h00);
        i_ssu_far_master.lines(1'b0, 1'b1);
        cyc(16);
        chk("scl line", {7'h0, sck & ~scl_oe}, 8'h01);
        i_ssu_far_master.lines(1'b1, 1'b1);
        cyc(16);
        chk("stop", {7'h0, flags.stop_condition_flag}, 8'h01);
        i_ssu_far_master.lines(1'b1, 1'b0);
        ctrl.wire_mode = SSU_WM_TWO_HOLD;
        ctrl.external_clock_select = 1'b1;
        cyc(8);
        load(8'hFF, 4'hE);
        clrovf();
        i_ssu_far_master.pulse();
        wovf();
        cyc(4);
        chk("count", {4'h0, count}, 8'h00);
        chk("scl oe", {7'h0, scl_oe}, 8'h01);
        clrovf();
        cyc(2);
        chk("scl oe", {7'h0, scl_oe}, 8'h00);
        $display("test two-wire done");
    endtask : t_tw
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        #2;
        rst_n = 1'b1;
        cyc(1);
        chk("shift", shift_register, SSU_DATA_RST);
        chk("count", {4'h0, count}, {4'h0, SSU_CNT_RST});
        chk("flags", {4'h0, flags}, 8'h00);
        $display("test reset done");
        t_soft();
        t_wrap();
        t_fifo();
        t_spi();
        t_tw();
        report_and_stop();
    end
endmodule : serial_shift_unit_bench
`default_nettype wire
